// >>> verilog/tsf_queue.sv
// tagged sample queue: storage control, readout port, options, flags
// Functional notes
// RULE1: store index advances once per push, 7 bits, wraps to zero.
// RULE2: fetch index advances per completed item fetch, wraps to zero.
// RULE3: fetch index is writable so host can re-fetch an item.
// RULE4: count lost items, saturating at the 7-bit maximum.
// RULE5: a completed item removal zeroes the lost-item tally.
// RULE6: read-only 8-bit pending count, up on push, down on fetch.
// RULE7: item is three bytes; third burst byte advances fetch index.
// RULE8: tag in top five bits, value left-justified below.
// RULE9: slots one to six tagged one to six while all earlier configured.
// RULE10: fence events push replacement value for slots one to three.
// RULE11: proximity tag only when slot one selects pilot on first LED.
// RULE12: sub-DAC update conversion carries its own tag.
// RULE13: fetch from empty queue returns the invalid tag.
// RULE14: when enabled, stamp item inserted every eight samples.
// RULE15: items pushed in slot order, repeating each period.
// RULE16: nearly-full sets when count reaches 128 minus headroom.
// RULE17: masked nearly-full drives the interrupt; status read clears.
// RULE18: overwrite replaces oldest when full; otherwise new item dropped.
// RULE19: type low re-flags every sample; high flags only new conditions.
// RULE20: clear-on-readout lets readout reads clear the flags too.
// RULE21: purge empties queue, zeroes indices, count and tally; self-clears.
// RULE22: first slot coded none ends the period's sequence.
// RULE23: empty fetch moves neither fetch index nor pending count.
`timescale 1ns/10ps
module tsf_queue (
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic        REG_WR,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_RD,
	output logic      [7:0]  REG_RDATA,
	input  wire logic        CONV_VALID,
	input  wire logic [18:0] CONV_VALUE,
	input  wire logic        CONV_FENCE,
	input  wire logic        CONV_SUBDAC,
	output logic             IRQ_OUT_N_O,
	output logic             IRQ_OUT_N_OE
);
	typedef struct packed {
		logic [6:0]  store_index;
		logic [6:0]  fetch_index;
		logic [6:0]  lost_item_tally;
		logic [7:0]  pending;
		logic [1:0]  byte_sel;
		logic [6:0]  headroom;
		logic        stamp_en;
		logic        clear_on_readout;
		logic        afull_type;
		logic        overwrite_oldest_enable;
		logic        mask_afull;
		logic        mask_drdy;
		logic [23:0] seq;
		logic [2:0]  slot;
		logic [2:0]  stamp_cnt;
		logic [18:0] period_cnt;
		logic        stamp_pend;
		logic        a_full;
		logic        drdy;
		logic        above_prev;
		logic [7:0]  rdata;
		logic        irq_oe;
	} tsf_state_t;

	tsf_state_t  cur_ff;
	tsf_state_t  nxt_st;

	logic [23:0] rd_item;
	logic [23:0] head_item;
	logic [23:0] push_item;
	logic [4:0]  conv_tag;
	logic        push_en;
	logic        wr_en;
	logic        pop;
	logic        full_eff;
	logic        stamp_push;
	logic        conv_ok;
	logic [3:0]  cur_code;
	logic [3:0]  next_code;
	logic [7:0]  threshold;
	logic        above;
	logic        readout_rd;
	logic        status_rd;
	logic [6:0]  diff;
	logic [7:0]  rd_mux;

	tsf_store u_store (
		.clk     (CLK),
		.wr_en   (wr_en),
		.wr_idx  (cur_ff.store_index),
		.wr_item (push_item),
		.rd_idx  (cur_ff.fetch_index),
		.rd_item (rd_item)
	);

	tsf_tagger u_tagger (
		.slot          (cur_ff.slot),
		.slot_one_code (cur_ff.seq[3:0]),
		.fence         (CONV_FENCE),
		.subdac        (CONV_SUBDAC),
		.tag           (conv_tag)
	);

	always_comb begin
		cur_code = cur_ff.seq[{cur_ff.slot, 2'b00} +: 4];
		if (cur_ff.slot == 3'd5) begin
			next_code = tsf_pkg::CODE_NONE;
		end else begin
			next_code = cur_ff.seq[{cur_ff.slot + 3'd1, 2'b00} +: 4];
		end
	end

	// a conversion is stored only for a configured slot
	assign conv_ok    = CONV_VALID && cur_code != tsf_pkg::CODE_NONE;
	// stamps wait for a cycle free of conversions; no extra buffer needed
	assign stamp_push = cur_ff.stamp_pend && !CONV_VALID;
	assign push_en    = conv_ok || stamp_push;

	always_comb begin
		if (conv_ok) begin
			push_item = {conv_tag, CONV_VALUE};                  // see RULE8
		end else begin
			push_item = {tsf_pkg::TAG_STAMP, cur_ff.period_cnt}; // see RULE14
		end
	end

	function automatic logic purge_req();
		purge_req = REG_WR && REG_ADDR == tsf_pkg::OFS_OPTIONS &&
			REG_WDATA[tsf_pkg::BIT_OPT_PURGE];
	endfunction

	assign readout_rd = REG_RD && REG_ADDR == tsf_pkg::OFS_READOUT;
	assign status_rd  = REG_RD && REG_ADDR == tsf_pkg::OFS_STATUS;
	assign pop = readout_rd && cur_ff.byte_sel == 2'd2 &&
		cur_ff.pending != 8'h00;                                 // see RULE23
	// a pop in the same cycle frees the slot the push needs
	assign full_eff = cur_ff.pending == tsf_pkg::DEPTH_COUNT && !pop;
	assign wr_en = push_en && !purge_req() &&
		(!full_eff || cur_ff.overwrite_oldest_enable);       // see RULE18

	always_comb begin
		if (cur_ff.pending == 8'h00) begin
			head_item = {tsf_pkg::TAG_INVALID, 19'h00000};        // see RULE13
		end else begin
			head_item = rd_item;
		end
	end

	always_comb begin
		case (cur_ff.byte_sel)
			2'd0: rd_mux = head_item[23:16];                     // see RULE7
			2'd1: rd_mux = head_item[15:8];
			default: rd_mux = head_item[7:0];
		endcase
	end

	assign threshold = tsf_pkg::DEPTH_COUNT - {1'b0, cur_ff.headroom};
	assign diff      = cur_ff.store_index - REG_WDATA[6:0];

	always_comb begin
		nxt_st = cur_ff;
		nxt_st.rdata = tsf_pkg::RST_REG;

		// exposure sequencing and periodic stamp request
		if (CONV_VALID) begin
			if (next_code == tsf_pkg::CODE_NONE ||
					cur_code == tsf_pkg::CODE_NONE) begin
				nxt_st.slot = 3'd0;                              // see RULE22
				nxt_st.period_cnt = cur_ff.period_cnt + 19'h00001;
				nxt_st.stamp_cnt = cur_ff.stamp_cnt + 3'd1;
				if (cur_ff.stamp_cnt == tsf_pkg::STAMP_PERIOD &&
						cur_ff.stamp_en) begin
					nxt_st.stamp_pend = 1'b1;                    // see RULE14
				end
			end else begin
				nxt_st.slot = cur_ff.slot + 3'd1;                // see RULE15
			end
		end
		if (stamp_push) begin
			nxt_st.stamp_pend = 1'b0;
		end

		// removal of a completed item
		if (readout_rd) begin
			if (cur_ff.byte_sel == 2'd2) begin
				nxt_st.byte_sel = 2'd0;
			end else begin
				nxt_st.byte_sel = cur_ff.byte_sel + 2'd1;
			end
		end
		if (pop) begin
			nxt_st.fetch_index = cur_ff.fetch_index + 7'h01;     // see RULE2
			nxt_st.lost_item_tally = tsf_pkg::RST_INDEX;         // see RULE5
			nxt_st.pending = cur_ff.pending - 8'h01;             // see RULE6
		end

		// push side
		if (push_en && full_eff) begin
			if (cur_ff.lost_item_tally != tsf_pkg::TALLY_MAX) begin
				nxt_st.lost_item_tally =
					cur_ff.lost_item_tally + 7'h01;              // see RULE4
			end
		end
		if (wr_en) begin
			nxt_st.store_index = cur_ff.store_index + 7'h01;     // see RULE1
			if (full_eff) begin
				// oldest item is overwritten, so the head moves with it
				nxt_st.fetch_index = cur_ff.fetch_index + 7'h01; // see RULE18
			end else begin
				nxt_st.pending = nxt_st.pending + 8'h01;         // see RULE6
			end
			nxt_st.drdy = 1'b1;
		end

		// nearly-full detection
		above = nxt_st.pending >= threshold;
		nxt_st.above_prev = above;
		if (status_rd || (readout_rd && cur_ff.clear_on_readout)) begin
			nxt_st.a_full = 1'b0;                                // see RULE20
			nxt_st.drdy = wr_en;
		end
		if (wr_en && above) begin
			if (!cur_ff.afull_type || !cur_ff.above_prev) begin
				nxt_st.a_full = 1'b1;                            // see RULE19
			end
		end

		// register reads
		if (REG_RD) begin
			case (REG_ADDR)
				tsf_pkg::OFS_STATUS: begin
					nxt_st.rdata[tsf_pkg::BIT_STAT_AFULL] =
						cur_ff.a_full;                           // see RULE17
					nxt_st.rdata[tsf_pkg::BIT_STAT_DRDY] = cur_ff.drdy;
				end
				tsf_pkg::OFS_IRQ_MASK: begin
					nxt_st.rdata[tsf_pkg::BIT_STAT_AFULL] =
						cur_ff.mask_afull;
					nxt_st.rdata[tsf_pkg::BIT_STAT_DRDY] =
						cur_ff.mask_drdy;
				end
				tsf_pkg::OFS_STORE:
					nxt_st.rdata = {1'b0, cur_ff.store_index};
				tsf_pkg::OFS_FETCH:
					nxt_st.rdata = {1'b0, cur_ff.fetch_index};
				tsf_pkg::OFS_TALLY:
					nxt_st.rdata = {1'b0, cur_ff.lost_item_tally};
				tsf_pkg::OFS_PENDING:
					nxt_st.rdata = cur_ff.pending;
				tsf_pkg::OFS_READOUT:
					nxt_st.rdata = rd_mux;
				tsf_pkg::OFS_WMARK:
					nxt_st.rdata = {1'b0, cur_ff.headroom};
				tsf_pkg::OFS_OPTIONS: begin
					nxt_st.rdata[tsf_pkg::BIT_OPT_STAMP] =
						cur_ff.stamp_en;
					nxt_st.rdata[tsf_pkg::BIT_OPT_CLR_RO] =
						cur_ff.clear_on_readout;
					nxt_st.rdata[tsf_pkg::BIT_OPT_TYPE] =
						cur_ff.afull_type;
					nxt_st.rdata[tsf_pkg::BIT_OPT_OVWR] =
						cur_ff.overwrite_oldest_enable;
				end
				tsf_pkg::OFS_SEQ0: nxt_st.rdata = cur_ff.seq[7:0];
				tsf_pkg::OFS_SEQ1: nxt_st.rdata = cur_ff.seq[15:8];
				tsf_pkg::OFS_SEQ2: nxt_st.rdata = cur_ff.seq[23:16];
				default: nxt_st.rdata = tsf_pkg::RST_REG;
			endcase
		end

		// register writes
		if (REG_WR) begin
			case (REG_ADDR)
				tsf_pkg::OFS_IRQ_MASK: begin
					nxt_st.mask_afull =
						REG_WDATA[tsf_pkg::BIT_STAT_AFULL];
					nxt_st.mask_drdy = REG_WDATA[tsf_pkg::BIT_STAT_DRDY];
				end
				tsf_pkg::OFS_FETCH: begin
					nxt_st.fetch_index = REG_WDATA[6:0];         // see RULE3
					nxt_st.byte_sel = 2'd0;
					// count follows the new head; equal indices keep full
					if (diff != 7'h00) begin
						nxt_st.pending = {1'b0, diff};
					end else if (cur_ff.pending !=
							tsf_pkg::DEPTH_COUNT) begin
						nxt_st.pending = 8'h00;
					end
				end
				tsf_pkg::OFS_WMARK:
					nxt_st.headroom = REG_WDATA[6:0];            // see RULE16
				tsf_pkg::OFS_OPTIONS: begin
					nxt_st.stamp_en = REG_WDATA[tsf_pkg::BIT_OPT_STAMP];
					nxt_st.clear_on_readout =
						REG_WDATA[tsf_pkg::BIT_OPT_CLR_RO];
					nxt_st.afull_type = REG_WDATA[tsf_pkg::BIT_OPT_TYPE];
					nxt_st.overwrite_oldest_enable =
						REG_WDATA[tsf_pkg::BIT_OPT_OVWR];
					if (!REG_WDATA[tsf_pkg::BIT_OPT_STAMP]) begin
						nxt_st.stamp_pend = 1'b0;                // see RULE14
					end
					if (REG_WDATA[tsf_pkg::BIT_OPT_PURGE]) begin
						// purge bit is never stored, so it reads back 0
						nxt_st.store_index = tsf_pkg::RST_INDEX; // see RULE21
						nxt_st.fetch_index = tsf_pkg::RST_INDEX;
						nxt_st.lost_item_tally = tsf_pkg::RST_INDEX;
						nxt_st.pending = tsf_pkg::RST_REG;
						nxt_st.byte_sel = 2'd0;
						nxt_st.above_prev = 1'b0;
					end
				end
				tsf_pkg::OFS_SEQ0: nxt_st.seq[7:0] = REG_WDATA;
				tsf_pkg::OFS_SEQ1: nxt_st.seq[15:8] = REG_WDATA;
				tsf_pkg::OFS_SEQ2: nxt_st.seq[23:16] = REG_WDATA;
				default: nxt_st.seq = nxt_st.seq;
			endcase
		end

		nxt_st.irq_oe = (nxt_st.a_full && nxt_st.mask_afull) ||
			(nxt_st.drdy && nxt_st.mask_drdy);                   // see RULE17
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_st;
		end
	end

	assign REG_RDATA    = cur_ff.rdata;
	assign IRQ_OUT_N_O  = 1'b0;
	assign IRQ_OUT_N_OE = cur_ff.irq_oe;
endmodule // tsf_queue

// >>> verilog/tsf_pkg.sv
// constants shared by the tagged sample queue
package tsf_pkg;
	localparam int DEPTH = 128;
	localparam logic [7:0] DEPTH_COUNT = 8'h80;
	// register offsets
	localparam logic [7:0] OFS_STATUS   = 8'h00;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h02;
	localparam logic [7:0] OFS_STORE    = 8'h04;
	localparam logic [7:0] OFS_FETCH    = 8'h05;
	localparam logic [7:0] OFS_TALLY    = 8'h06;
	localparam logic [7:0] OFS_PENDING  = 8'h07;
	localparam logic [7:0] OFS_READOUT  = 8'h08;
	localparam logic [7:0] OFS_WMARK    = 8'h09;
	localparam logic [7:0] OFS_OPTIONS  = 8'h0a;
	localparam logic [7:0] OFS_SEQ0     = 8'h20;
	localparam logic [7:0] OFS_SEQ1     = 8'h21;
	localparam logic [7:0] OFS_SEQ2     = 8'h22;
	// field positions
	localparam int BIT_STAT_AFULL = 7;
	localparam int BIT_STAT_DRDY  = 6;
	localparam int BIT_OPT_STAMP  = 5;
	localparam int BIT_OPT_PURGE  = 4;
	localparam int BIT_OPT_CLR_RO = 3;
	localparam int BIT_OPT_TYPE   = 2;
	localparam int BIT_OPT_OVWR   = 1;
	// reset values
	localparam logic [6:0] RST_INDEX = 7'h00;
	localparam logic [7:0] RST_REG   = 8'h00;
	// tally ceiling and stamp interval
	localparam logic [6:0] TALLY_MAX    = 7'h7f;
	localparam logic [2:0] STAMP_PERIOD = 3'h7;
	// exposure codes
	localparam logic [3:0] CODE_NONE  = 4'h0;
	localparam logic [3:0] CODE_PILOT = 4'h8;
	// item tags
	localparam logic [4:0] TAG_FENCE1  = 5'h0d;
	localparam logic [4:0] TAG_PROX    = 5'h19;
	localparam logic [4:0] TAG_SUBDAC  = 5'h1d;
	localparam logic [4:0] TAG_INVALID = 5'h1e;
	localparam logic [4:0] TAG_STAMP   = 5'h1f;
endpackage

// >>> verilog/tsf_store.sv
// item storage array with one write port and one asynchronous read port
`timescale 1ns/10ps
module tsf_store (
	input  wire logic        clk,
	input  wire logic        wr_en,
	input  wire logic [6:0]  wr_idx,
	input  wire logic [23:0] wr_item,
	input  wire logic [6:0]  rd_idx,
	output logic      [23:0] rd_item
);
	// no reset: contents are only visible through the counted indices
	logic [23:0] mem [tsf_pkg::DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_item;
		end
	end

	assign rd_item = mem[rd_idx];
endmodule // tsf_store

// >>> verilog/tsf_tagger.sv
// picks the tag for one conversion result
`timescale 1ns/10ps
module tsf_tagger (
	input  wire logic [2:0] slot,
	input  wire logic [3:0] slot_one_code,
	input  wire logic       fence,
	input  wire logic       subdac,
	output logic      [4:0] tag
);
	always_comb begin
		if (subdac) begin
			tag = tsf_pkg::TAG_SUBDAC;                    // see RULE12
		end else if (fence && slot < 3'd3) begin
			tag = tsf_pkg::TAG_FENCE1 + {2'b00, slot};    // see RULE10
		end else if (slot == 3'd0 &&
				slot_one_code == tsf_pkg::CODE_PILOT) begin
			tag = tsf_pkg::TAG_PROX;                      // see RULE11
		end else begin
			tag = {2'b00, slot} + 5'h01;                  // see RULE9
		end
	end
endmodule // tsf_tagger

// >>> testbench/tsf_queue_monitor.sv
// port-level assertions for the tagged sample queue
`timescale 1ns/10ps
module tsf_queue_chk (
	input wire logic       CLK,
	input wire logic       RESET,
	input wire logic [7:0] REG_ADDR,
	input wire logic       REG_WR,
	input wire logic [7:0] REG_WDATA,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic       CONV_VALID,
	input wire logic       IRQ_OUT_N_O,
	input wire logic       IRQ_OUT_N_OE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	// a quiet cycle: no conversion, nothing read or written
	sequence s_gap;
		!CONV_VALID && !REG_WR && !REG_RD;
	endsequence
	sequence s_purge;
		REG_WR && REG_ADDR == tsf_pkg::OFS_OPTIONS && !CONV_VALID
			&& REG_WDATA[tsf_pkg::BIT_OPT_PURGE];
	endsequence
	property p_rdata_idle;
		!REG_RD |=> REG_RDATA == 8'h00;
	endproperty
	property p_od_data;
		IRQ_OUT_N_O == 1'b0;
	endproperty
	property p_fetch_rw;
		(REG_WR && REG_ADDR == tsf_pkg::OFS_FETCH && !CONV_VALID) ##1 s_gap
			##1 (REG_RD && REG_ADDR == tsf_pkg::OFS_FETCH)
			|=> REG_RDATA == ($past(REG_WDATA, 3) & 8'h7f);
	endproperty
	property p_count_ro;
		(REG_RD && REG_ADDR == tsf_pkg::OFS_PENDING && !CONV_VALID) ##1 s_gap
			##1 (REG_WR && REG_ADDR == tsf_pkg::OFS_PENDING && !CONV_VALID)
			##1 s_gap ##1 (REG_RD && REG_ADDR == tsf_pkg::OFS_PENDING)
			|=> REG_RDATA == $past(REG_RDATA, 4);
	endproperty
	property p_purge;
		s_purge ##1 s_gap ##1 (REG_RD && REG_ADDR == tsf_pkg::OFS_STORE)
			|=> REG_RDATA == 8'h00;
	endproperty
	property p_empty;
		s_purge ##1 s_gap ##1 (REG_RD && REG_ADDR == tsf_pkg::OFS_READOUT)
			|=> REG_RDATA[7:3] == tsf_pkg::TAG_INVALID;
	endproperty
	property p_irq_cause;
		$rose(IRQ_OUT_N_OE) |-> $past(CONV_VALID, 2) || $past(CONV_VALID)
			|| $past(REG_WR) || $past(REG_WR, 2);
	endproperty
	// a stamp only goes out right after a conversion, so two cycles
	// without a conversion rule out any push that could set a flag again
	property p_status_clr;
		!$past(CONV_VALID) && REG_RD && REG_ADDR == tsf_pkg::OFS_STATUS
			&& !CONV_VALID |=> !IRQ_OUT_N_OE;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
	a_od_data: assert property (p_od_data) else $error("irq pin data not low");
	a_fetch_rw: assert property (p_fetch_rw) else $error("fetch index lost");
	a_count_ro: assert property (p_count_ro) else $error("count was written");
	a_purge: assert property (p_purge) else $error("purge left index");
	a_empty: assert property (p_empty) else $error("empty tag wrong");
	a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
	a_status_clr: assert property (p_status_clr) else $error("irq not cleared");
endmodule // tsf_queue_chk

bind tsf_queue tsf_queue_chk i_tsf_queue_chk (.CLK(CLK), .RESET(RESET),
	.REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
	.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CONV_VALID(CONV_VALID),
	.IRQ_OUT_N_O(IRQ_OUT_N_O), .IRQ_OUT_N_OE(IRQ_OUT_N_OE));

// >>> testbench/tsf_host_model.sv
// host processor model speaking the register strobe port
`timescale 1ns/10ps
module tsf_host_model (
	input  wire logic       clk,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	// callers enter just after a rising edge; one access spans two cycles
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~v;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		@(posedge clk);
	endtask
	// an item is consumed when the third byte of a readout burst is read
	task automatic rd_item(output logic [23:0] v);
		rd(tsf_pkg::OFS_READOUT, v[23:16]);
		rd(tsf_pkg::OFS_READOUT, v[15:8]);
		rd(tsf_pkg::OFS_READOUT, v[7:0]);
	endtask
endmodule // tsf_host_model

// >>> testbench/testbench.sv
// self-checking bench for the tagged sample queue
`timescale 1ns/10ps
module testbench;
	logic        clk;
	logic        reset;
	logic        cv;
	logic [18:0] cval;
	logic        cfence;
	logic        csub;
	logic [7:0]  addr;
	logic        wr;
	logic [7:0]  wdata;
	logic        rd;
	logic [7:0]  rdata;
	logic        irq_o;
	logic        irq_oe;
	logic [7:0]  d;
	logic [23:0] it;
	logic [7:0]  ns;
	int          bad_count;
	int          n_tests;
	localparam logic [7:0] REGS [7] = '{8'h03, 8'h04, 8'h05, 8'h06,
		8'h07, 8'h09, 8'h0a};

	tsf_queue i_tsf_queue (.CLK(clk), .RESET(reset), .REG_ADDR(addr),
		.REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata),
		.CONV_VALID(cv), .CONV_VALUE(cval), .CONV_FENCE(cfence),
		.CONV_SUBDAC(csub), .IRQ_OUT_N_O(irq_o), .IRQ_OUT_N_OE(irq_oe));
	tsf_host_model h (.clk(clk), .reg_addr(addr), .reg_wr(wr),
		.reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata));

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic push(input logic [18:0] v, input logic f, input logic s);
		cv <= 1'b1;
		cval <= v;
		cfence <= f;
		csub <= s;
		@(posedge clk);
		cv <= 1'b0;
		cval <= ~v;
		@(posedge clk);
	endtask
	task automatic irq_is(input logic exp);
		#1 chk(irq_oe, exp);
		@(posedge clk);
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// whole run needs under nine hundred cycles
	initial begin
		#100000;
		bad_count++;
		test_done;
	end
	initial begin
		reset = 1'b1;
		{cv, cval, cfence, csub} = '0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		foreach (REGS[k]) begin
			h.rd(REGS[k], d);
			chk(d, 8'h00);
		end
		$display("reset values done");
		h.wr(8'h20, 8'h21);
		for (int i = 0; i < 3; i++) push(19'h01000 + 19'(i), 1'b0, 1'b0);
		h.rd(tsf_pkg::OFS_PENDING, d);
		chk(d, 8'h03);
		h.rd(tsf_pkg::OFS_STORE, d);
		chk(d, 8'h03);
		for (int i = 0; i < 3; i++) begin
			h.rd_item(it);
			chk(it, {5'(i % 2 + 1), 19'h01000 + 19'(i)});
		end
		h.rd_item(it);
		chk(it[23:19], tsf_pkg::TAG_INVALID);
		h.rd(tsf_pkg::OFS_FETCH, d);
		chk(d, 8'h03);
		$display("slot order done");
		h.wr(tsf_pkg::OFS_FETCH, 8'h01);
		h.rd(tsf_pkg::OFS_FETCH, d);
		chk(d, 8'h01);
		h.rd(tsf_pkg::OFS_PENDING, d);
		h.wr(tsf_pkg::OFS_PENDING, 8'h55);
		h.rd(tsf_pkg::OFS_PENDING, d);
		chk(d, 8'h02);
		h.rd_item(it);
		chk(it, {5'h02, 19'h01001});
		push(19'h02000, 1'b1, 1'b0);
		push(19'h02001, 1'b0, 1'b1);
		push(19'h02002, 1'b0, 1'b0);
		h.wr(8'h20, 8'h08);
		push(19'h02003, 1'b0, 1'b0);
		h.rd_item(it);
		chk(it, {5'h01, 19'h01002});
		h.rd_item(it);
		chk(it, {5'h0e, 19'h02000});
		h.rd_item(it);
		chk(it, {tsf_pkg::TAG_SUBDAC, 19'h02001});
		h.rd_item(it);
		chk(it, {5'h02, 19'h02002});
		h.rd_item(it);
		chk(it, {tsf_pkg::TAG_PROX, 19'h02003});
		$display("tags done");
		h.wr(tsf_pkg::OFS_OPTIONS, 8'h10);
		for (int i = 4; i < 8; i++) begin
			h.rd(8'(i), d);
			chk(d, 8'h00);
		end
		h.rd(tsf_pkg::OFS_OPTIONS, d);
		chk(d, 8'h00);
		h.wr(8'h20, 8'h01);
		h.wr(tsf_pkg::OFS_IRQ_MASK, 8'h80);
		h.wr(tsf_pkg::OFS_WMARK, 8'h7e);
		push(19'h30000, 1'b0, 1'b0);
		irq_is(1'b0);
		push(19'h30001, 1'b0, 1'b0);
		irq_is(1'b1);
		h.rd(tsf_pkg::OFS_STATUS, d);
		chk(d, 8'hc0);
		irq_is(1'b0);
		push(19'h30002, 1'b0, 1'b0);
		irq_is(1'b1);
		h.rd(tsf_pkg::OFS_STATUS, d);
		h.wr(tsf_pkg::OFS_OPTIONS, 8'h04);
		push(19'h30003, 1'b0, 1'b0);
		irq_is(1'b0);
		for (int i = 4; i < 128; i++) push(19'h30000 + 19'(i), 1'b0, 1'b0);
		h.rd(tsf_pkg::OFS_STORE, d);
		chk(d, 8'h00);
		repeat (130) push(19'h7ffff, 1'b0, 1'b0);
		h.rd(tsf_pkg::OFS_TALLY, d);
		chk(d, 8'h7f);
		h.rd(tsf_pkg::OFS_PENDING, d);
		chk(d, 8'h80);
		h.rd_item(it);
		chk(it, {5'h01, 19'h30000});
		h.rd(tsf_pkg::OFS_TALLY, d);
		chk(d, 8'h00);
		h.rd(tsf_pkg::OFS_FETCH, d);
		chk(d, 8'h01);
		h.wr(tsf_pkg::OFS_OPTIONS, 8'h02);
		push(19'h30080, 1'b0, 1'b0);
		push(19'h30081, 1'b0, 1'b0);
		h.rd(tsf_pkg::OFS_PENDING, d);
		chk(d, 8'h80);
		h.rd_item(it);
		chk(it, {5'h01, 19'h30002});
		h.rd(tsf_pkg::OFS_STATUS, d);
		h.wr(tsf_pkg::OFS_OPTIONS, 8'h0a);
		push(19'h30082, 1'b0, 1'b0);
		irq_is(1'b1);
		h.rd_item(it);
		irq_is(1'b0);
		$display("watermark and overflow done");
		h.wr(tsf_pkg::OFS_OPTIONS, 8'h10);
		h.rd_item(it);
		chk(it[23:19], tsf_pkg::TAG_INVALID);
		h.wr(tsf_pkg::OFS_OPTIONS, 8'h20);
		repeat (16) push(19'h04444, 1'b0, 1'b0);
		h.rd(tsf_pkg::OFS_PENDING, d);
		chk(d, 8'h12);
		ns = 8'h00;
		repeat (18) begin
			h.rd_item(it);
			if (it[23:19] == tsf_pkg::TAG_STAMP) begin
				ns++;
			end
		end
		chk(ns, 8'h02);
		$display("stamps done");
		h.wr(tsf_pkg::OFS_IRQ_MASK, 8'h40);
		irq_is(1'b1);
		chk(irq_o, 1'b0);
		h.rd(tsf_pkg::OFS_IRQ_MASK, d);
		chk(d, 8'h40);
		h.rd(tsf_pkg::OFS_STATUS, d);
		chk(d, 8'hc0);
		irq_is(1'b0);
		$display("data ready irq done");
		test_done;
	end
endmodule // testbench
